/* core/sic_channel.sv */
// Simple I2C master channel: registers, rate generation, byte engine.
// Assumes Avalon-MM master and open-drain pads resolved outside.
`timescale 1ns/1ps
module sic_channel
  import sic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             irq
);
  sic_req_t   req;
  sic_lines_t lines;
  sic_state_t st_q, st_d;
  logic       ack_q, ack_d;
  logic [6:0] div_q, div_d;
  logic [15:0] mode_q, mode_d;
  logic [7:0] psel_q, psel_d;
  logic       en_q, en_d;
  logic [2:0] out_q, out_d;
  logic       bff_q, bff_d, ovf_q, ovf_d;
  logic [1:0] ist_q, ist_d, ien_q, ien_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic       go_q, go_d;
  logic       scl_q, scl_d, sdo_q, sdo_d;
  logic [31:0] rdata_q, rdata_d;
  logic       tick, half, rx_mode, wr, rd, end_ev, ovf_ev;
  logic [3:0] pre_code;

  assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata};
  // One wait state per access so read data always come from a flop
  assign avs_waitrequest = (req.rd | req.wr) & ~ack_q;
  assign wr = req.wr & ack_q;
  assign rd = req.rd & ack_q;
  assign rx_mode = mode_q[SIC_DIR_BIT];
  // Clock select chooses upper or lower prescaler field
  assign pre_code = mode_q[SIC_CKS_BIT] ? psel_q[7:4] : psel_q[3:0];

  sic_prescaler u_pre (
    .clk   (clk),
    .reset (reset),
    .code  (pre_code),
    .tick  (tick)
  );

  sic_scl_gen u_scl (
    .clk   (clk),
    .reset (reset),
    .run   (st_q == SIC_LOW || st_q == SIC_HIGH),
    .tick  (tick),
    .div   (div_q),
    .half  (half)
  );

  // Register file and bus handshake
  always_comb begin
    ack_d  = (req.rd | req.wr) & ~ack_q;
    div_d  = div_q;
    mode_d = mode_q;
    psel_d = psel_q;
    en_d   = en_q;
    out_d  = out_q;
    ien_d  = ien_q;
    tx_d   = tx_q;
    rdata_d = rdata_q;
    if (wr) begin
      unique case (req.addr)
        SIC_ADDR_DATA: begin
          div_d = req.wdata[SIC_DIV_MSB:SIC_DIV_LSB];
          tx_d  = req.wdata[7:0];
        end
        SIC_ADDR_MODE:  mode_d = req.wdata[15:0];
        SIC_ADDR_PSEL:  psel_d = req.wdata[7:0];
        SIC_ADDR_START: if (req.wdata[0]) en_d = 1'b1;
        SIC_ADDR_STOP:  if (req.wdata[0]) en_d = 1'b0;
        SIC_ADDR_OUT:   out_d  = req.wdata[2:0];
        SIC_ADDR_IRQEN: ien_d  = req.wdata[1:0];
        default: ;
      endcase
    end
    if (req.rd & ~ack_q) begin
      unique case (req.addr)
        SIC_ADDR_DATA:   rdata_d = {16'h0000, div_q, 1'b0, rx_q};
        SIC_ADDR_STATUS: rdata_d = {29'h0, st_q != SIC_IDLE, ovf_q, bff_q};
        SIC_ADDR_MODE:   rdata_d = {16'h0000, mode_q};
        SIC_ADDR_PSEL:   rdata_d = {24'h000000, psel_q};
        SIC_ADDR_ENST:   rdata_d = {31'h0, en_q};
        SIC_ADDR_OUT:    rdata_d = {29'h0, out_q};
        SIC_ADDR_IRQST:  rdata_d = {30'h0, ist_q};
        SIC_ADDR_IRQEN:  rdata_d = {30'h0, ien_q};
        default:         rdata_d = SIC_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q   <= 1'b0;
      div_q   <= SIC_DIV_RST;
      mode_q  <= 16'h0000;
      psel_q  <= SIC_PSEL_RST;
      en_q    <= 1'b0;
      out_q   <= SIC_OUT_RST;
      ien_q   <= 2'h0;
      tx_q    <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      div_q   <= div_d;
      mode_q  <= mode_d;
      psel_q  <= psel_d;
      en_q    <= en_d;
      out_q   <= out_d;
      ien_q   <= ien_d;
      tx_q    <= tx_d;
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata = rdata_q;

  // Byte engine: 8 data bits plus ACK, started by a data write while enabled
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    scl_d  = scl_q;
    sdo_d  = sdo_q;
    rx_d   = rx_q;
    go_d   = go_q;
    end_ev = 1'b0;
    unique case (st_q)
      SIC_IDLE: begin
        scl_d = out_q[SIC_SCL_BIT]; // Software levels drive stop/start
        sdo_d = out_q[SIC_SDA_BIT];
        if (wr && req.addr == SIC_ADDR_DATA && en_q) begin
          sh_d  = rx_mode ? 8'hff : req.wdata[7:0];
          bit_d = 4'h0;
          go_d  = 1'b1;
        end
        // Start on a tick so the first low phase is as long as the rest
        if (go_q && tick) begin
          go_d  = 1'b0;
          scl_d = 1'b0;
          sdo_d = rx_mode ? 1'b1 : sh_q[7];
          st_d  = SIC_LOW;
        end
      end
      SIC_LOW: if (half) begin
        scl_d = 1'b1;
        st_d  = SIC_HIGH;
      end
      SIC_HIGH: if (half) begin
        scl_d = 1'b0;
        if (bit_q < SIC_BITS) begin
          sh_d  = {sh_q[6:0], sda_in};
          bit_d = 4'(bit_q + 4'h1);
        end else begin
          bit_d = 4'(bit_q + 4'h1);
        end
        if (bit_q == SIC_BITS) begin
          st_d  = SIC_DONE;
          sdo_d = out_q[SIC_SDA_BIT];
        end else if (bit_q == 4'(SIC_BITS - 4'h1)) begin
          // ACK slot: receiver drives ACK only while output enabled
          sdo_d = rx_mode ? ~out_q[SIC_SOE_BIT] : 1'b1;
          st_d  = SIC_LOW;
        end else begin
          sdo_d = rx_mode ? 1'b1 : sh_q[6];
          st_d  = SIC_LOW;
        end
      end
      SIC_DONE: begin
        if (rx_mode) rx_d = sh_q;
        end_ev = 1'b1;
        st_d   = SIC_IDLE;
      end
      default: st_d = SIC_IDLE;
    endcase
    if (!en_q) begin
      go_d  = 1'b0;
      st_d  = SIC_IDLE;
      scl_d = out_q[SIC_SCL_BIT];
      sdo_d = out_q[SIC_SDA_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q  <= SIC_IDLE;
      sh_q  <= 8'h00;
      bit_q <= 4'h0;
      scl_q <= 1'b1;
      sdo_q <= 1'b1;
      rx_q  <= 8'h00;
      go_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      sh_q  <= sh_d;
      bit_q <= bit_d;
      scl_q <= scl_d;
      sdo_q <= sdo_d;
      rx_q  <= rx_d;
      go_q  <= go_d;
    end
  end

  // Status flags and interrupt: set wins over clear
  assign ovf_ev = end_ev & rx_mode & bff_q;
  always_comb begin
    bff_d = bff_q;
    ovf_d = ovf_q;
    ist_d = ist_q;
    if (rd && req.addr == SIC_ADDR_DATA) bff_d = 1'b0;
    if (wr && req.addr == SIC_ADDR_FCLR && req.wdata[SIC_OVF_BIT]) ovf_d = 1'b0;
    if (wr && req.addr == SIC_ADDR_IRQCLR) ist_d = ist_q & ~req.wdata[1:0];
    if (end_ev && rx_mode) bff_d = 1'b1;
    if (ovf_ev) ovf_d = 1'b1;
    if (end_ev) ist_d[SIC_EV_END] = 1'b1;
    if (ovf_ev) ist_d[SIC_EV_OVF] = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bff_q <= 1'b0;
      ovf_q <= 1'b0;
      ist_q <= 2'h0;
    end else begin
      bff_q <= bff_d;
      ovf_q <= ovf_d;
      ist_q <= ist_d;
    end
  end
  assign irq = |(ist_q & ien_q);

  // Open-drain lines: enable active low, only ever pull low
  assign lines    = '{scl_oe_n: scl_q, sda_oe_n: sdo_q};
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = lines.scl_oe_n;
  assign sda_oe_n = lines.sda_oe_n;

  a_stop_clears_en: assert property (@(posedge clk) disable iff (reset)
    (wr && req.addr == SIC_ADDR_STOP && req.wdata[0]) |=> !en_q)
    else $error("Stop trigger did not clear enable");
  a_start_sets_en: assert property (@(posedge clk) disable iff (reset)
    (wr && req.addr == SIC_ADDR_START && req.wdata[0] &&
     !(req.addr == SIC_ADDR_STOP)) |=> en_q)
    else $error("Start trigger did not set enable");
  a_read_clears_bff: assert property (@(posedge clk) disable iff (reset)
    (rd && req.addr == SIC_ADDR_DATA && !end_ev) |=> !bff_q)
    else $error("Data read did not clear buffer full");
  a_fclr_ovf: assert property (@(posedge clk) disable iff (reset)
    (wr && req.addr == SIC_ADDR_FCLR && req.wdata[SIC_OVF_BIT] && !ovf_ev) |=> !ovf_q)
    else $error("Flag clear did not clear overrun");
  a_ovf_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(ovf_q) |-> $past(end_ev) && $past(bff_q))
    else $error("Overrun without a second reception");
  a_clk_select: assert property (@(posedge clk) disable iff (reset)
    mode_q[SIC_CKS_BIT] |-> pre_code == psel_q[7:4])
    else $error("Wrong prescaler field selected");
  a_no_ack_off: assert property (@(posedge clk) disable iff (reset)
    (st_q == SIC_HIGH && half && rx_mode && bit_q == 4'h7 && out_q[SIC_SOE_BIT] == 1'b0)
    |=> sda_oe_n) else $error("ACK driven while output disabled");
  a_scl_toggle: assert property (@(posedge clk) disable iff (reset)
    (st_q == SIC_LOW && half && en_q) |=> scl_oe_n)
    else $error("SCL did not rise after low half");
endmodule

/* core/sic_pkg.sv */
// Constants, register map and carrier types of the simple I2C channel.
// Assumes a 32-bit Avalon-MM slave port with waitrequest and one 40 MHz clock.
package sic_pkg;

  // Byte addresses of the registers
  localparam logic [7:0] SIC_ADDR_DATA   = 8'h00; // channel_data_and_divider_register
  localparam logic [7:0] SIC_ADDR_STATUS = 8'h04; // channel_status_register
  localparam logic [7:0] SIC_ADDR_FCLR   = 8'h08; // flag_clear_trigger_register
  localparam logic [7:0] SIC_ADDR_MODE   = 8'h0c; // channel_mode_register
  localparam logic [7:0] SIC_ADDR_PSEL   = 8'h10; // prescaler_select_register
  localparam logic [7:0] SIC_ADDR_START  = 8'h14; // channel_start_trigger_register
  localparam logic [7:0] SIC_ADDR_STOP   = 8'h18; // channel_stop_trigger_register
  localparam logic [7:0] SIC_ADDR_ENST   = 8'h1c; // channel_enabled_status_register
  localparam logic [7:0] SIC_ADDR_OUT    = 8'h20; // serial_output_enable + line levels
  localparam logic [7:0] SIC_ADDR_IRQST  = 8'h24; // sticky event status
  localparam logic [7:0] SIC_ADDR_IRQCLR = 8'h28; // write-one-to-clear
  localparam logic [7:0] SIC_ADDR_IRQEN  = 8'h2c; // event enable

  // Field positions
  localparam int SIC_DIV_LSB  = 9;
  localparam int SIC_DIV_MSB  = 15;
  localparam int SIC_CKS_BIT  = 15;
  localparam int SIC_BFF_BIT  = 0;
  localparam int SIC_OVF_BIT  = 1;
  localparam int SIC_BUSY_BIT = 2;
  localparam int SIC_SOE_BIT  = 0;
  localparam int SIC_SDA_BIT  = 1;
  localparam int SIC_SCL_BIT  = 2;
  localparam int SIC_DIR_BIT  = 0;  // Mode bit 0: 1 = receive
  localparam int SIC_EV_END   = 0;
  localparam int SIC_EV_OVF   = 1;

  // Reset values and limits
  localparam logic [6:0]  SIC_DIV_RST  = 7'h7f;
  localparam logic [7:0]  SIC_PSEL_RST = 8'h00;
  localparam logic [2:0]  SIC_OUT_RST  = 3'h6;   // Lines high, output disabled
  localparam logic [3:0]  SIC_PRS_MAX  = 4'hb;
  localparam logic [3:0]  SIC_BITS     = 4'h8;
  localparam logic [31:0] SIC_UNMAPPED = 32'h0000_0000;

  typedef enum logic [2:0] {
    SIC_IDLE = 3'b000,
    SIC_LOW  = 3'b001,
    SIC_HIGH = 3'b010,
    SIC_DONE = 3'b011
  } sic_state_t;

  // Avalon request bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sic_req_t;

  // Line drive bundle: output enables are active low
  typedef struct packed {
    logic scl_oe_n;
    logic sda_oe_n;
  } sic_lines_t;

  // Prescaler code to tick divide: 2^k cycles, every cycle for codes above 11
  function automatic logic [11:0] sic_pre_mask(input logic [3:0] k);
    sic_pre_mask = (k > SIC_PRS_MAX) ? 12'h000 : 12'((12'h001 << k) - 12'h001);
  endfunction

endpackage

/* core/sic_prescaler.sv */
// Operation clock tick generator: one tick every 2^k system clocks, every clock for codes above 11.
// Assumes the code is stable while the channel runs.
`timescale 1ns/1ps
module sic_prescaler
  import sic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] code,
  output logic            tick
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] mask;

  // Free-running count; tick when all masked bits are set
  always_comb begin
    mask  = sic_pre_mask(code);
    cnt_d = 12'(cnt_q + 12'h001);
    tick  = ((cnt_q & mask) == mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_tick_code0: assert property (@(posedge clk) disable iff (reset)
    (code == 4'h0) |-> tick) else $error("Code zero must tick every cycle");
endmodule

/* core/sic_scl_gen.sv */
// Symmetric SCL phase generator from operation clock ticks.
// Assumes divider is 1..127; a zero divider gives a half period of one tick.
`timescale 1ns/1ps
module sic_scl_gen
  import sic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [6:0] div,
  output logic            half
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;

  // Half period is div+1 ticks, so both phases are equal
  always_comb begin
    cnt_d = cnt_q;
    half  = 1'b0;
    if (!run) begin
      cnt_d = 7'h00;
    end else if (tick) begin
      if (cnt_q >= div) begin
        cnt_d = 7'h00;
        half  = 1'b1;
      end else begin
        cnt_d = 7'(cnt_q + 7'h01);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_half_bound: assert property (@(posedge clk) disable iff (reset)
    half |-> tick && run) else $error("Half period without tick");
endmodule

/* verification/sic_slave_model.sv */
// Slave stand-in on the two-wire bus: shifts bits in and out, answers ACK.
// Assumes the bench resolves both lines with pull-ups; no clock stretching.
`timescale 1ns/1ps
module sic_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       frame,
  input  wire logic       rd_mode,
  input  wire logic [7:0] tx_byte,
  output logic            sda_low,
  output logic [7:0]      rx_byte,
  output logic            ack_bit
);
  int idx;

  // Released until the first frame
  initial sda_low = 1'b0;

  // New frame: the first read bit must already be on the line
  always @(posedge frame) begin
    idx = 0;
    sda_low = rd_mode & ~tx_byte[7];
  end

  // Release on frame end so the pull-up, not a stale bit, sets the level
  always @(negedge frame) sda_low = 1'b0;

  // Data changes only while SCL is low; write frames get an ACK
  always @(negedge scl) if (frame) begin
    if (idx > 0) begin
      sda_low = rd_mode ? (idx < 8 && !tx_byte[3'(7 - idx)]) : (idx == 8);
    end
    idx++;
  end

  // Sample on SCL rise; the ninth rise carries the acknowledge
  always @(posedge scl) if (frame) begin
    if (idx <= 8) rx_byte = {rx_byte[6:0], sda};
    else ack_bit = sda;
  end
endmodule

/* verification/simple_i2c_master_rate_and_errors_tb.sv */
// Self-checking bench for the simple I2C channel and its SCL rate logic.
// Assumes one 40 MHz clock, Avalon-MM access and a pulled-up two-wire bus.
`timescale 1ns/1ps
module simple_i2c_master_rate_and_errors_tb;
  import sic_pkg::*;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address, tx_byte, rx_byte, b;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, scl, sda;
  logic        frame, rd_mode, sda_low, ack_bit, prev;
  int          failures, tests_run, run;
  int          lo_q[$], hi_q[$];

  // Open-drain lines with pull-ups
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & ~sda_low;

  sic_channel uut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq));

  sic_slave_model slave (.scl(scl), .sda(sda), .frame(frame), .rd_mode(rd_mode),
    .tx_byte(tx_byte), .sda_low(sda_low), .rx_byte(rx_byte), .ack_bit(ack_bit));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // SCL phase lengths inside a frame; the idle high before it is skipped
  always @(negedge clk) if (frame) begin
    if (scl_oe_n === prev) run++;
    else begin
      if (!prev) lo_q.push_back(run);
      else if (lo_q.size() > 0) hi_q.push_back(run);
      run = 1;
    end
    prev = scl_oe_n;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One access; a spare edge first keeps back-to-back calls from clashing
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Hold the request until the rising edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1, "bus timeout");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
  endtask

  // One byte frame; the expected half period is worked out here
  task automatic xfer(input logic [3:0] k, input logic cks, input logic [6:0] dv,
                      input logic rdm, input logic soe);
    int n, half;
    b = 8'($urandom);
    half = (int'(dv) + 1) << k;
    bus(1, SIC_ADDR_STOP, 32'h1);
    bus(1, SIC_ADDR_PSEL, cks ? {24'h0, k, 4'h1} : {24'h0, 4'(11 - k), k});
    bus(1, SIC_ADDR_MODE, {16'h0, cks, 14'h0, rdm});
    bus(1, SIC_ADDR_START, 32'h1);
    bus(1, SIC_ADDR_OUT, {29'h0, 2'b11, soe});
    lo_q.delete();
    hi_q.delete();
    prev = 1'b1;
    rd_mode = rdm;
    tx_byte = b;
    frame = 1'b1;
    bus(1, SIC_ADDR_DATA, {16'h0, dv, 1'b0, b});
    n = 0;
    while (irq !== 1'b1 && n < 80000) begin
      @(negedge clk);
      n++;
    end
    frame = 1'b0;
    chk(32'(lo_q.size()), 32'd9, "scl pulses");
    foreach (lo_q[i]) chk(32'(lo_q[i]), 32'(half), "scl low");
    foreach (hi_q[i]) chk(32'(hi_q[i]), 32'(half), "scl high");
    if (rdm) chk({31'h0, ack_bit}, {31'h0, !soe}, "ack");
    else chk({24'h0, rx_byte}, {24'h0, b}, "sent byte");
    bus(0, SIC_ADDR_IRQST, 0);
    chk(rd & 32'h1, 32'h1, "end event");
    bus(1, SIC_ADDR_IRQCLR, 32'h1);
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    logic [7:0]  ra[7];
    logic [31:0] rv[7];
    ra = '{SIC_ADDR_ENST, SIC_ADDR_OUT, SIC_ADDR_PSEL, SIC_ADDR_IRQST,
           SIC_ADDR_STATUS, SIC_ADDR_DATA, 8'h30};
    rv = '{0, 32'h6, 0, 0, 0, 32'hfe00, 0};
    void'($urandom(32'h3affcab1));
    {reset, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {frame, rd_mode, tx_byte} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (ra[i]) begin
      bus(0, ra[i], 0);
      chk(rd, rv[i], "reset value");
    end
    $display("test reset values done");
    bus(1, SIC_ADDR_START, 32'h1);
    bus(0, SIC_ADDR_ENST, 0);
    chk(rd, 32'h1, "enabled");
    bus(1, SIC_ADDR_IRQEN, 32'h3);
    for (int k = 0; k < 10; k++) xfer(4'(k), 1'(k), 7'h1, 0, 1);
    xfer(4'($urandom % 3), 1'($urandom), 7'(1 + $urandom % 7), 0, 1);
    $display("test rate done");
    xfer(4'h1, 0, 7'h2, 1, 1);
    bus(0, SIC_ADDR_DATA, 0);
    chk(rd & 32'hff, {24'h0, b}, "rx byte");
    xfer(4'h1, 0, 7'h2, 1, 1);
    xfer(4'h1, 0, 7'h2, 1, 0);
    bus(0, SIC_ADDR_STATUS, 0);
    chk(rd & 32'h3, 32'h3, "overrun");
    chk({31'h0, irq}, 32'h1, "irq on");
    bus(0, SIC_ADDR_DATA, 0);
    bus(0, SIC_ADDR_STATUS, 0);
    chk(rd & 32'h3, 32'h2, "full cleared");
    bus(1, SIC_ADDR_FCLR, rd);
    bus(0, SIC_ADDR_STATUS, 0);
    chk(rd & 32'h3, 32'h0, "flag cleared");
    bus(1, SIC_ADDR_IRQEN, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1, SIC_ADDR_IRQCLR, 32'h2);
    bus(1, SIC_ADDR_IRQEN, 32'h3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test overrun done");
    bus(1, SIC_ADDR_STOP, 32'h1);
    bus(0, SIC_ADDR_ENST, 0);
    chk(rd, 32'h0, "stopped");
    bus(1, SIC_ADDR_DATA, 32'h0203);
    repeat (20) @(negedge clk);
    chk({31'h0, scl_oe_n}, 32'h1, "no frame when stopped");
    bus(1, SIC_ADDR_OUT, 32'h1);
    repeat (2) @(negedge clk);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h0, "both low");
    bus(1, SIC_ADDR_OUT, 32'h5);
    repeat (2) @(negedge clk);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h2, "scl up");
    bus(1, SIC_ADDR_OUT, 32'h7);
    repeat (2) @(negedge clk);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "bus free");
    chk({30'h0, scl_out, sda_out}, 32'h0, "open drain");
    bus(1, SIC_ADDR_START, 32'h1);
    bus(0, SIC_ADDR_ENST, 0);
    chk(rd, 32'h1, "restarted");
    $display("test stop condition done");
    complete_run();
  end
endmodule
